// ===== core/pushbutton_power_sequencer.sv
// Purpose: rail sequencing, manual reset and status pins of a power manager
// Assumes: analog comparators deliver clean synchronous levels
// Notes:   rails come out as enables, open-drain pins as value and enable
`include "pb_seq_consts.svh"
`default_nettype none

// Behaviour
// R1 - resistor-path press requests power-up, direct press is a timed manual reset
// R2 - short manual press gives warm reset, held until 130ms after release
// R3 - long manual press cycles all rails, registers back to defaults
// R4 - after a power cycle, power hold needed within 260ms
// R5 - button status pin pulled low while the button is asserted
// R6 - at startup reset held low until timeout after rail 1 is good
// R7 - manual reset drives reset low at once, until release plus timeout
// R8 - interrupt pin pulled low while any unmasked condition is present
// R9 - interrupt sources come out of reset masked, software unmasks them
// R10 - software validates interrupts against status bits
// R11 - start on resistor press, or charger plus hold within 260ms
// R12 - rail 1 first, then rails 2 and 5 with reset asserted
// R13 - reset released when timer ends with rail 1 still good
// R14 - power enable drives rails 3 and 4, hold must come before release
// R15 - no power hold at button release aborts boot, all rails off
// R16 - system stays on while hold is high, dropping hold shuts down
// R17 - dropping power enable sleeps rails 3 and 4, raising it wakes them
// R18 - option: button or hold enables rails 6, 7; rail 5 optional
// R19 - otherwise software switches rails 6 and 7 after boot
// R20 - serial slave at address 1011011x, single-byte writes and reads
// R21 - serial port up to 400kHz, msb first, every byte acknowledged
// R22 - timers count clock cycles, limits are parameters
module pushbutton_power_sequencer
   import pb_seq_pkg::*;
#(
   parameter int unsigned PRESS_CYC    = `PRESS_CYCLES,
   parameter int unsigned RST_CYC      = `RESET_TIMEOUT_CYC,
   parameter int unsigned HOLD_CYC     = `HOLD_WINDOW_CYC,
   parameter bit          HAS_RAIL5    = 1'b1,
   parameter bit          AUTO_RAIL67  = 1'b0
)
(
   input  wire logic clock,
   input  wire logic reset,
   input  wire logic button_input_n,
   input  wire logic button_direct,
   input  wire logic power_hold,
   input  wire logic power_enable_req,
   input  wire logic charger_input,
   input  wire logic rail1_output_good,
   input  wire logic supply_level_low,
   input  wire logic fault_event,
   input  wire logic scl_in,
   input  wire logic sda_in,
   output logic      sda_o,
   output logic      sda_oe_n,
   output rails_t    rails,
   output logic      reset_out_o,
   output logic      reset_out_oe_n,
   output logic      button_status_out_o,
   output logic      button_status_out_oe_n,
   output logic      interrupt_request_out_o,
   output logic      interrupt_request_out_oe_n
);

   // -----
   // timer limits
   // -----
   localparam logic [31:0] PRESS_LAST = 32'(PRESS_CYC - 1); // R22
   localparam logic [31:0] RST_LAST   = 32'(RST_CYC - 1);
   localparam logic [31:0] HOLD_LAST  = 32'(HOLD_CYC - 1);

   seq_regs_t  r_reg;
   seq_regs_t  r_next;
   reg_write_t wr;
   logic [7:0] rd_addr;
   logic [7:0] rd_data;
   logic [7:0] status;
   logic       press_direct;
   logic       press_soft;
   logic       pressed;
   logic       core_on;
   logic       proc_on;
   logic       auto67;

   // -----
   // serial register port
   // -----
   i2c_byte_slave u_port
   (
      .clock    (clock),
      .reset    (reset),
      .scl_in   (scl_in),
      .sda_in   (sda_in),
      .sda_o    (sda_o),
      .sda_oe_n (sda_oe_n),
      .rd_data  (rd_data),
      .rd_addr  (rd_addr),
      .wr       (wr)
   );

   assign status = {1'h0, r_reg.state, power_hold, fault_event,
                    supply_level_low, rail1_output_good};

   always_comb
   begin
      unique case (rd_addr)
         `REG_CTRL:   rd_data = r_reg.ctrl;
         `REG_MASK:   rd_data = r_reg.mask;
         `REG_STATUS: rd_data = status;
         default:     rd_data = 8'h00;
      endcase
   end

   // -----
   // button decoding
   // -----
   // front end tells the press paths apart
   assign pressed      = ~button_input_n;
   assign press_direct = pressed & button_direct;  // R1
   assign press_soft   = pressed & ~button_direct; // R1

   // -----
   // sequencer
   // -----
   always_comb
   begin
      r_next = r_reg;

      if (wr.strobe)
      begin
         if (wr.addr == `REG_CTRL)
            r_next.ctrl = wr.data;
         else if (wr.addr == `REG_MASK)
            r_next.mask = wr.data; // R9
      end

      // charger window: hold must follow a valid charger within the limit
      if (!charger_input)
         r_next.chg_cnt = 32'h00000000;
      else if (r_reg.chg_cnt <= HOLD_LAST)
         r_next.chg_cnt = r_reg.chg_cnt + 32'h00000001;

      unique case (r_reg.state)
         SEQ_OFF:
         begin
            r_next.timer = 32'h00000000;
            if (press_soft) // R11
            begin
               r_next.state = SEQ_RAIL1;
               r_next.window_mode = 1'h0;
            end
            else if (charger_input && power_hold && r_reg.chg_cnt <= HOLD_LAST) // R11
            begin
               r_next.state = SEQ_RAIL1;
               r_next.window_mode = 1'h1;
            end
         end

         SEQ_RAIL1:
         begin
            r_next.timer = 32'h00000000;
            if (rail1_output_good) // R12
               r_next.state = SEQ_RESET;
         end

         SEQ_RESET:
         begin
            // a dip of rail 1 restarts the timeout
            if (!rail1_output_good)
               r_next.timer = 32'h00000000; // R6
            else if (r_reg.timer >= RST_LAST) // R13
            begin
               r_next.state = SEQ_BOOT;
               r_next.timer = 32'h00000000;
            end
            else
               r_next.timer = r_reg.timer + 32'h00000001;
         end

         SEQ_BOOT:
         begin
            r_next.timer = r_reg.timer + 32'h00000001;
            if (power_hold) // R14
               r_next.state = SEQ_ON;
            else if (r_reg.window_mode && r_reg.timer >= HOLD_LAST) // R4
               r_next.state = SEQ_OFF;
            else if (!r_reg.window_mode && !pressed) // R15
               r_next.state = SEQ_OFF;
         end

         SEQ_ON:
         begin
            r_next.timer = 32'h00000000;
            r_next.press_cnt = 32'h00000000;
            if (!power_hold) // R16
               r_next.state = SEQ_OFF;
            else if (press_direct) // R7
               r_next.state = SEQ_WARM;
         end

         SEQ_WARM:
         begin
            if (pressed)
            begin
               r_next.timer = 32'h00000000;
               r_next.press_cnt = r_reg.press_cnt + 32'h00000001;
               if (r_reg.press_cnt >= PRESS_LAST) // R3
               begin
                  r_next.state = SEQ_COLD;
                  r_next.ctrl = `CTRL_RESET;
                  r_next.mask = `MASK_RESET;
               end
            end
            else if (r_reg.timer >= RST_LAST) // R2
               r_next.state = power_hold ? SEQ_ON : SEQ_OFF;
            else
               r_next.timer = r_reg.timer + 32'h00000001;
         end

         SEQ_COLD:
         begin
            r_next.timer = 32'h00000000;
            r_next.ctrl = `CTRL_RESET;
            r_next.mask = `MASK_RESET;
            if (!pressed) // R3
            begin
               r_next.state = SEQ_RAIL1;
               r_next.window_mode = 1'h1; // R4
            end
         end

         default:
            r_next.state = SEQ_OFF;
      endcase

      // -----
      // rail enables and pins
      // -----
      core_on = r_next.state == SEQ_RESET || r_next.state == SEQ_BOOT ||
                r_next.state == SEQ_ON || r_next.state == SEQ_WARM;
      proc_on = r_next.state == SEQ_BOOT || r_next.state == SEQ_ON ||
                r_next.state == SEQ_WARM;
      auto67  = pressed | power_hold;

      r_next.rails.rail_1 = core_on || r_next.state == SEQ_RAIL1; // R12
      r_next.rails.rail_2 = core_on; // R12
      r_next.rails.rail_5 = core_on & HAS_RAIL5; // R18
      r_next.rails.rail_3 = proc_on & power_enable_req; // R17
      r_next.rails.rail_4 = proc_on & power_enable_req; // R17
      if (AUTO_RAIL67)
      begin
         r_next.rails.rail_6 = r_next.rails.rail_1 & auto67; // R18
         r_next.rails.rail_7 = r_next.rails.rail_1 & auto67; // R18
      end
      else
      begin
         // software switches them once the processor has booted
         r_next.rails.rail_6 = proc_on & r_next.ctrl[`CTRL_RAIL6_BIT];
         r_next.rails.rail_7 = proc_on & r_next.ctrl[`CTRL_RAIL7_BIT];
      end

      // reset low whenever the processor is not allowed to run
      r_next.rst_low = !(r_next.state == SEQ_BOOT || r_next.state == SEQ_ON); // R7

      r_next.pbstat_low = pressed; // R5

      r_next.irq_low = (supply_level_low & r_next.mask[`MASK_SUPPLY_BIT]) |
                       (fault_event & r_next.mask[`MASK_FAULT_BIT]); // R8
   end

   always_ff @(posedge clock or posedge reset)
   begin
      if (reset)
      begin
         r_reg <= '{state: SEQ_OFF, ctrl: `CTRL_RESET, mask: `MASK_RESET,
                    rst_low: 1'h1, default: '0};
      end
      else
      begin
         r_reg <= r_next;
      end
   end

   // -----
   // outputs
   // -----
   // open-drain: pull low only, enable active low
   assign rails                      = r_reg.rails;
   assign reset_out_o                = 1'h0;
   assign reset_out_oe_n             = ~r_reg.rst_low;
   assign button_status_out_o        = 1'h0;
   assign button_status_out_oe_n     = ~r_reg.pbstat_low;
   assign interrupt_request_out_o    = 1'h0;
   assign interrupt_request_out_oe_n = ~r_reg.irq_low;

endmodule

`default_nettype wire

// ===== core/pb_seq_consts.svh
// Purpose: constants of the push-button power sequencer
// Assumes: 200 MHz device clock
// Notes:   times in ms, cycle counts derived from them
`ifndef PB_SEQ_CONSTS_SVH
`define PB_SEQ_CONSTS_SVH

// -----
// timing
// -----
`define CLOCK_HZ           200000000
`define PRESS_TIME_MS      130
`define RESET_TIMEOUT_MS   130
`define HOLD_WINDOW_MS     260
`define PRESS_CYCLES       (`PRESS_TIME_MS * (`CLOCK_HZ / 1000))
`define RESET_TIMEOUT_CYC  (`RESET_TIMEOUT_MS * (`CLOCK_HZ / 1000))
`define HOLD_WINDOW_CYC    (`HOLD_WINDOW_MS * (`CLOCK_HZ / 1000))

// -----
// serial port
// -----
`define SLAVE_ADDR         7'h5B

// -----
// register map and fields
// -----
`define REG_CTRL           8'h00
`define REG_MASK           8'h01
`define REG_STATUS         8'h02
`define CTRL_RAIL6_BIT     0
`define CTRL_RAIL7_BIT     1
`define MASK_SUPPLY_BIT    0
`define MASK_FAULT_BIT     1
`define CTRL_RESET         8'h00
`define MASK_RESET         8'h00

`endif

// ===== core/pb_seq_pkg.sv
// Purpose: types of the push-button power sequencer
// Assumes: nothing
// Notes:   constants live in pb_seq_consts.svh
`default_nettype none

package pb_seq_pkg;

   typedef enum logic [2:0]
   {
      SEQ_OFF   = 3'b000,
      SEQ_RAIL1 = 3'b001,
      SEQ_RESET = 3'b010,
      SEQ_BOOT  = 3'b011,
      SEQ_ON    = 3'b100,
      SEQ_WARM  = 3'b101,
      SEQ_COLD  = 3'b110
   } seq_state_t;

   typedef enum logic [2:0]
   {
      PH_IDLE  = 3'b000,
      PH_ADDR  = 3'b001,
      PH_ACKA  = 3'b010,
      PH_REG   = 3'b011,
      PH_ACKR  = 3'b100,
      PH_WDATA = 3'b101,
      PH_ACKW  = 3'b110,
      PH_RDATA = 3'b111
   } i2c_phase_t;

   typedef struct packed
   {
      logic rail_7;
      logic rail_6;
      logic rail_5;
      logic rail_4;
      logic rail_3;
      logic rail_2;
      logic rail_1;
   } rails_t;

   typedef struct packed
   {
      logic       strobe;
      logic [7:0] addr;
      logic [7:0] data;
   } reg_write_t;

   typedef struct packed
   {
      i2c_phase_t phase;
      logic [3:0] bit_cnt;
      logic [7:0] shift;
      logic [7:0] reg_idx;
      logic       rw;
      logic       master_ack;
      logic       sda_drive;
      logic       scl_q;
      logic       sda_q;
      reg_write_t wr;
   } i2c_state_t;

   typedef struct packed
   {
      seq_state_t  state;
      logic [31:0] timer;
      logic [31:0] press_cnt;
      logic [31:0] chg_cnt;
      logic        window_mode;
      logic [7:0]  ctrl;
      logic [7:0]  mask;
      rails_t      rails;
      logic        rst_low;
      logic        pbstat_low;
      logic        irq_low;
   } seq_regs_t;

endpackage

`default_nettype wire

// ===== core/i2c_byte_slave.sv
// Purpose: byte-wide serial register slave, write-byte and read-byte
// Assumes: scl_in and sda_in already synchronous to clock
// Notes:   one data byte per transfer, later bytes get no ack
`include "pb_seq_consts.svh"
`default_nettype none

module i2c_byte_slave
   import pb_seq_pkg::*;
(
   input  wire logic       clock,
   input  wire logic       reset,
   input  wire logic       scl_in,
   input  wire logic       sda_in,
   output logic            sda_o,
   output logic            sda_oe_n,
   input  wire logic [7:0] rd_data,
   output logic [7:0]      rd_addr,
   output reg_write_t      wr
);

   i2c_state_t r_reg;
   i2c_state_t r_next;
   logic       scl_rise;
   logic       scl_fall;
   logic       start_cond;
   logic       stop_cond;

   assign scl_rise   = scl_in & ~r_reg.scl_q;
   assign scl_fall   = ~scl_in & r_reg.scl_q;
   assign start_cond = scl_in & r_reg.scl_q & r_reg.sda_q & ~sda_in;
   assign stop_cond  = scl_in & r_reg.scl_q & ~r_reg.sda_q & sda_in;

   // -----
   // protocol engine
   // -----
   always_comb
   begin
      r_next = r_reg;
      r_next.scl_q = scl_in;
      r_next.sda_q = sda_in;
      r_next.wr.strobe = 1'h0;
      if (start_cond)
      begin
         r_next.phase = PH_ADDR;
         r_next.bit_cnt = 4'h0;
         r_next.sda_drive = 1'h0;
      end
      else if (stop_cond)
      begin
         r_next.phase = PH_IDLE;
         r_next.sda_drive = 1'h0;
      end
      else if (scl_rise)
      begin
         if (r_reg.phase == PH_ADDR || r_reg.phase == PH_REG || r_reg.phase == PH_WDATA)
         begin
            r_next.shift = {r_reg.shift[6:0], sda_in}; // R21
            r_next.bit_cnt = r_reg.bit_cnt + 4'h1;
         end
         else if (r_reg.phase == PH_RDATA && r_reg.bit_cnt == 4'h8)
            r_next.master_ack = ~sda_in;
      end
      else if (scl_fall)
      begin
         unique case (r_reg.phase)
            PH_IDLE:
               r_next.sda_drive = 1'h0;
            PH_ADDR:
               if (r_reg.bit_cnt == 4'h8)
               begin
                  if (r_reg.shift[7:1] == `SLAVE_ADDR) // R20
                  begin
                     r_next.phase = PH_ACKA;
                     r_next.rw = r_reg.shift[0];
                     r_next.sda_drive = 1'h1; // R21
                  end
                  else
                     r_next.phase = PH_IDLE;
               end
            PH_ACKA:
               if (r_reg.rw)
               begin
                  r_next.phase = PH_RDATA;
                  r_next.sda_drive = ~rd_data[7];
                  r_next.shift = {rd_data[6:0], 1'h0};
                  r_next.bit_cnt = 4'h1;
               end
               else
               begin
                  r_next.phase = PH_REG;
                  r_next.sda_drive = 1'h0;
                  r_next.bit_cnt = 4'h0;
               end
            PH_REG:
               if (r_reg.bit_cnt == 4'h8)
               begin
                  r_next.reg_idx = r_reg.shift;
                  r_next.phase = PH_ACKR;
                  r_next.sda_drive = 1'h1;
               end
            PH_ACKR:
            begin
               r_next.phase = PH_WDATA;
               r_next.sda_drive = 1'h0;
               r_next.bit_cnt = 4'h0;
            end
            PH_WDATA:
               if (r_reg.bit_cnt == 4'h8)
               begin
                  r_next.wr.strobe = 1'h1; // R20
                  r_next.wr.addr = r_reg.reg_idx;
                  r_next.wr.data = r_reg.shift;
                  r_next.phase = PH_ACKW;
                  r_next.sda_drive = 1'h1;
               end
            PH_ACKW:
            begin
               r_next.phase = PH_IDLE;
               r_next.sda_drive = 1'h0;
            end
            PH_RDATA:
               if (r_reg.bit_cnt == 4'h8)
               begin
                  // free the line for the master's ack
                  r_next.sda_drive = 1'h0;
                  r_next.bit_cnt = 4'h9;
               end
               else if (r_reg.bit_cnt == 4'h9)
                  r_next.phase = PH_IDLE;
               else
               begin
                  r_next.sda_drive = ~r_reg.shift[7];
                  r_next.shift = {r_reg.shift[6:0], 1'h0};
                  r_next.bit_cnt = r_reg.bit_cnt + 4'h1;
               end
         endcase
      end
   end

   always_ff @(posedge clock or posedge reset)
   begin
      if (reset)
      begin
         r_reg <= '{phase: PH_IDLE, scl_q: 1'h1, sda_q: 1'h1, default: '0};
      end
      else
      begin
         r_reg <= r_next;
      end
   end

   assign sda_o    = 1'h0;
   assign sda_oe_n = ~r_reg.sda_drive;
   assign rd_addr  = r_reg.reg_idx;
   assign wr       = r_reg.wr;

endmodule

`default_nettype wire

// ===== dv/pb_seq_properties.sv
// Purpose: pin-level checks of the power sequencer
// Assumes: one clock domain, reset async active high
// Notes:   bound into the sequencer below
`default_nettype none

module pb_seq_properties
   import pb_seq_pkg::*;
#(
   parameter int unsigned RST_CYC = 16
)
(
   input wire logic   clock,
   input wire logic   reset,
   input wire logic   button_input_n,
   input wire logic   button_direct,
   input wire logic   power_hold,
   input wire logic   power_enable_req,
   input wire logic   rail1_output_good,
   input wire logic   supply_level_low,
   input wire logic   fault_event,
   input wire rails_t rails,
   input wire logic   reset_out_oe_n,
   input wire logic   button_status_out_oe_n,
   input wire logic   interrupt_request_out_oe_n
);
   // -----
   // helper and sequences
   // -----
   localparam int RST_M2 = RST_CYC - 2;
   int unsigned good_run_reg;

   // power-good run length, a dip restarts it
   always_ff @(posedge clock or posedge reset)
   begin
      if (reset)
         good_run_reg <= 0;
      else
         good_run_reg <= rail1_output_good ? good_run_reg + 1 : 0;
   end

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (reset);

   sequence warm_release_s;
      !reset_out_oe_n && !button_input_n && button_direct ##1 button_input_n;
   endsequence

   sequence rail2_cause_s;
      $past(rail1_output_good) && rails.rail_1 && !reset_out_oe_n;
   endsequence

   AST_STATUS_PIN: assert property (!$past(reset) |-> button_status_out_oe_n == $past(button_input_n))
      else $error("status pin off the button");
   AST_IRQ_IDLE: assert property (!fault_event && !supply_level_low |=> interrupt_request_out_oe_n)
      else $error("irq without cause");
   AST_IRQ_MASKED: assert property ($fell(reset) |-> interrupt_request_out_oe_n [*8])
      else $error("irq unmasked after reset");
   AST_RAIL_ORDER: assert property ($rose(rails.rail_2) |-> rail2_cause_s)
      else $error("rail 2 before rail 1 good");
   AST_RST_RELEASE: assert property ($rose(reset_out_oe_n) |-> good_run_reg >= RST_CYC)
      else $error("reset released early");
   AST_WARM_ASSERT: assert property (!button_input_n && button_direct && reset_out_oe_n && rails.rail_1
      |=> !reset_out_oe_n)
      else $error("manual reset not at once");
   AST_WARM_HOLD: assert property (!reset_out_oe_n && !button_input_n && button_direct |=> !reset_out_oe_n)
      else $error("reset released while pressed");
   AST_WARM_TIMEOUT: assert property (warm_release_s |-> !reset_out_oe_n ##RST_M2 !reset_out_oe_n)
      else $error("warm reset short");
   AST_SLEEP: assert property (reset_out_oe_n && rails.rail_2 && !power_enable_req
      |=> !rails.rail_3 && !rails.rail_4)
      else $error("rails 3 4 on in sleep");
   AST_WAKE: assert property (reset_out_oe_n && power_hold && power_enable_req && button_input_n
      |=> rails.rail_3 && rails.rail_4 && rails.rail_1)
      else $error("rails 3 4 off when enabled");
   AST_HOLD_DROP: assert property (reset_out_oe_n && button_input_n && $fell(power_hold)
      |-> ##[1:2] rails == 7'h00)
      else $error("rails on after hold drop");
   AST_ABORT: assert property (reset_out_oe_n && !power_hold && $rose(button_input_n) |=> rails == 7'h00)
      else $error("boot not aborted");
endmodule

bind pushbutton_power_sequencer pb_seq_properties #(.RST_CYC(RST_CYC)) seq_props (.*);

`default_nettype wire

// ===== dv/host_model.sv
// Purpose: host processor answering the power handshakes
// Assumes: boots a fixed time after reset is released
// Notes:   loses all state while rail 1 is off
`default_nettype none

module host_model
#(
   parameter int BOOT_DLY = 6
)
(
   input  wire logic clock,
   input  wire logic reset,
   input  wire logic rail_on,
   input  wire logic released,
   input  wire logic hold_allow,
   input  wire logic sleep_req,
   output logic      power_hold,
   output logic      power_enable_req
);
   timeunit 1ns;
   timeprecision 1ps;
   // -----
   // boot and handshakes
   // -----
   int cnt;

   always @(posedge clock or posedge reset)
   begin
      if (reset || !rail_on)
      begin
         cnt <= 0;
         power_hold <= 1'b0;
         power_enable_req <= 1'b0;
      end
      else
      begin
         if (released && cnt < BOOT_DLY)
            cnt <= cnt + 1;
         power_enable_req <= (cnt == BOOT_DLY) && !sleep_req;
         power_hold <= ((cnt == BOOT_DLY) || power_hold) && hold_allow;
      end
   end
endmodule

`default_nettype wire

// ===== dv/pushbutton_power_sequencer_bench.sv
// Purpose: self-checking bench of the power sequencer
// Assumes: shortened timers, host model on the far side
// Notes:   serial port bit-banged at 400kHz
`default_nettype none

module pushbutton_power_sequencer_bench
   import pb_seq_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   // -----
   // wiring
   // -----
   localparam int RST = 16;
   localparam int PRESS = 20;
   localparam int HOLD = 40;
   localparam int Q = 125;
   logic   clock, reset, button_input_n, button_direct, charger_input, good, supply_level_low;
   logic   fault_event, scl, sda_m, sda_line, sda_o, sda_oe_n, power_hold, power_enable_req;
   logic   hold_allow, sleep_req, reset_out_oe_n, button_status_out_oe_n, interrupt_request_out_oe_n;
   logic   [2:0] acks;
   rails_t rails;
   int     n_mismatch, samples_checked;

   assign sda_line = sda_m & (sda_oe_n | sda_o);

   pushbutton_power_sequencer #(.PRESS_CYC(PRESS), .RST_CYC(RST), .HOLD_CYC(HOLD)) DUT
   (
      .clock(clock), .reset(reset), .button_input_n(button_input_n), .button_direct(button_direct),
      .power_hold(power_hold), .power_enable_req(power_enable_req), .charger_input(charger_input),
      .rail1_output_good(good), .supply_level_low(supply_level_low), .fault_event(fault_event),
      .scl_in(scl), .sda_in(sda_line), .sda_o(sda_o), .sda_oe_n(sda_oe_n), .rails(rails),
      .reset_out_o(), .reset_out_oe_n(reset_out_oe_n), .button_status_out_o(),
      .button_status_out_oe_n(button_status_out_oe_n), .interrupt_request_out_o(),
      .interrupt_request_out_oe_n(interrupt_request_out_oe_n)
   );

   host_model host
   (
      .clock(clock), .reset(reset), .rail_on(rails.rail_1), .released(reset_out_oe_n), .hold_allow(hold_allow),
      .sleep_req(sleep_req), .power_hold(power_hold), .power_enable_req(power_enable_req)
   );

   initial
   begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end

   // rail 1 reaches power-good one cycle after its enable
   always @(posedge clock) good <= rails.rail_1;

   // -----
   // tasks
   // -----
   task automatic tick(input int n);
      repeat (n) @(posedge clock);
   endtask

   task automatic chk(input logic ok, input string msg);
      samples_checked++;
      if (ok !== 1'b1)
      begin
         $display("[ERR] t=%0t %s", $time, msg);
         n_mismatch++;
      end
   endtask

   task automatic summarize();
      $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   // k below 7 is a rail bit, 7 is the reset pin
   task automatic wait_sig(input int k, input logic v, input int lim);
      for (int i = 0; i < lim && ((k < 7) ? rails[k] : reset_out_oe_n) !== v; i++)
         tick(1);
      if (((k < 7) ? rails[k] : reset_out_oe_n) !== v)
      begin
         chk(1'b0, "wait limit");
         summarize();
      end
   endtask

   task automatic sbit(input logic b, output logic s);
      sda_m <= b;
      tick(Q);
      scl <= 1'b1;
      tick(Q);
      s = sda_line;
      tick(Q);
      scl <= 1'b0;
      tick(Q);
   endtask

   task automatic i2c_write(input logic [23:0] frame, output logic [2:0] ack);
      logic s;
      sda_m <= 1'b0;
      tick(Q);
      scl <= 1'b0;
      tick(Q);
      for (int n = 2; n >= 0; n--)
      begin
         for (int i = 7; i >= 0; i--)
            sbit(frame[n * 8 + i], s);
         sbit(1'b1, s);
         ack[n] = (s === 1'b0);
      end
      sda_m <= 1'b0;
      tick(Q);
      scl <= 1'b1;
      tick(Q);
      sda_m <= 1'b1;
      tick(Q);
   endtask

   // -----
   // main sequence
   // -----
   initial
   begin
      {reset, button_input_n, scl, sda_m, hold_allow, fault_event} = 6'h3F;
      {button_direct, charger_input, good, supply_level_low, sleep_req} = 5'h00;
      n_mismatch = 0;
      samples_checked = 0;
      tick(3);
      reset <= 1'b0;
      button_input_n <= 1'b0;
      button_direct <= 1'b1;
      charger_input <= 1'b1;
      tick(10);
      chk(rails === 7'h00 && interrupt_request_out_oe_n === 1'b1, "off start");
      chk(button_status_out_oe_n === 1'b0, "status");
      {button_input_n, charger_input, button_direct, hold_allow} <= 4'h8;
      tick(3);
      chk(button_status_out_oe_n === 1'b1, "status");
      button_input_n <= 1'b0;
      wait_sig(0, 1'b1, 4);
      chk(rails === 7'h01, "rail 1 first");
      wait_sig(1, 1'b1, 4);
      chk(rails === 7'h13 && reset_out_oe_n === 1'b0, "rails 2 5");
      wait_sig(7, 1'b1, RST + 4);
      wait_sig(2, 1'b1, 12);
      chk(rails === 7'h1F, "rails 3 4");
      button_input_n <= 1'b1;
      tick(3);
      chk(rails === 7'h00, "abort");
      $display("test abort done");
      hold_allow <= 1'b1;
      button_input_n <= 1'b0;
      wait_sig(2, 1'b1, RST + 24);
      tick(2);
      button_input_n <= 1'b1;
      tick(4);
      chk(rails === 7'h1F && reset_out_oe_n === 1'b1, "held on");
      i2c_write({7'h2B, 1'b0, 8'h00, 8'h03}, acks);
      chk(acks === 3'b000 && rails === 7'h1F, "foreign address");
      i2c_write({7'h5B, 1'b0, 8'h00, 8'h03}, acks);
      tick(2);
      chk(acks === 3'b111 && rails === 7'h7F, "rails 6 7");
      chk(interrupt_request_out_oe_n === 1'b1, "irq masked");
      i2c_write({7'h5B, 1'b0, 8'h01, 8'h02}, acks);
      tick(2);
      chk(interrupt_request_out_oe_n === 1'b0, "irq fault");
      {fault_event, supply_level_low} <= 2'b01;
      tick(3);
      chk(interrupt_request_out_oe_n === 1'b1, "irq supply masked");
      supply_level_low <= 1'b0;
      $display("test serial done");
      sleep_req <= 1'b1;
      wait_sig(2, 1'b0, 4);
      chk(rails === 7'h73, "sleep");
      sleep_req <= 1'b0;
      wait_sig(2, 1'b1, 4);
      button_direct <= 1'b1;
      button_input_n <= 1'b0;
      wait_sig(7, 1'b0, 3);
      tick(5);
      button_input_n <= 1'b1;
      tick(RST - 2);
      chk(reset_out_oe_n === 1'b0 && rails === 7'h7F, "warm early");
      wait_sig(7, 1'b1, 6);
      $display("test warm done");
      button_input_n <= 1'b0;
      wait_sig(0, 1'b0, PRESS + 6);
      hold_allow <= 1'b0;
      button_input_n <= 1'b1;
      wait_sig(0, 1'b1, 6);
      wait_sig(0, 1'b0, HOLD + RST + 8);
      {hold_allow, button_direct, button_input_n} <= 3'b100;
      wait_sig(2, 1'b1, RST + 24);
      tick(2);
      button_input_n <= 1'b1;
      tick(3);
      chk(rails === 7'h1F, "registers reloaded");
      hold_allow <= 1'b0;
      wait_sig(0, 1'b0, 4);
      chk(rails === 7'h00, "shutdown");
      $display("test cold done");
      summarize();
   end
endmodule

`default_nettype wire
